// File: include/lpn_if.sv
// Link between the host controller and the driver's register and speed pin side.
// Both ends share one clock; every signal changes right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
interface lpn_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic speed_pin;
	logic [7:0] speed_ana;

	modport dev (input wr, input rd, input addr, input wdata, input speed_pin, input speed_ana,
		output rdata);
	modport hst (output wr, output rd, output addr, output wdata, output speed_pin,
		output speed_ana, input rdata);
endinterface
`default_nettype wire

// File: include/lpn_pkg.sv
// Constants, types and register map for the low-power and NV access block.
// Assumes a single 40 MHz clock shared by both ends and synchronous pin inputs.
// Summary of operation
// - Overvoltage stops drive until supply falls back
// - Sleep or standby stops driving all phases
// - Sleep kills regulator, serial port, volatile registers
// - Standby keeps regulator, registers and serial port
// - Analog: low for entry, high exit; sleep higher
// - PWM: pin low enters, pin high exits standby
// - Serial: zero speed enters, non-zero exits standby
// - Sleep exit only through the speed pin
// - Far end meets minimum duty to wake
// - Host keeps speed pin at defined level
// - Sleep entry (PWM, analog): pin low or level below entry threshold
// - Sleep entry: disable, host_bit_a, enable, zero speed
// - Seven 16-bit NV words behind shadow registers
// - Host waits 10 ms, disables motor first
// - Key 0000 then C0DE, poll ready flag
// - Mass write copies shadows into NV store
// - Mass read copies NV store into shadows
// - Host re-enables motor after NV access
// - Program stationary, power cycle, read back
// - Resistance code from first config register
// - Back-EMF code from second config register
// - Decode mantissa shifted left by shift
// - Power-on copies NV store into shadows
`default_nettype none
package lpn_pkg;
	localparam int CLK_MHZ = 40;
	localparam int CLK_NS = 25;

	localparam logic [7:0] A_SPEED = 8'h30;
	localparam logic [7:0] A_KEY = 8'h31;
	localparam logic [7:0] A_STATUS = 8'h32;
	localparam logic [7:0] A_NVCTL = 8'h35;
	localparam logic [7:0] A_MCTL = 8'h60;
	localparam logic [7:0] A_CFG_FIRST = 8'h90;
	localparam logic [7:0] A_CFG_LAST = 8'h96;

	localparam int NV_WORDS = 7;
	localparam int NV_W = 16;
	localparam logic [15:0] NV_ERASED = 16'h0000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] KEY_CLEAR = 16'h0000;
	localparam logic [15:0] KEY_OPEN = 16'hC0DE;

	localparam int SPD_LSB = 0;
	localparam int SPD_W = 9;
	localparam int HOST_A_BIT = 15;
	localparam int MOTOR_DISABLE_BIT_BIT = 15;
	localparam int READY_BIT = 0;
	localparam int ACC_MODE_LSB = 0;
	localparam int WREN_BIT = 2;
	localparam int REFRESH_BIT = 3;
	localparam int SHADOW_BIT = 4;
	localparam logic [1:0] ACC_MODE_MASS = 2'h2;

	localparam int CFG_RES = 0;
	localparam int CFG_BEMF = 1;
	localparam int MANT_LSB = 0;
	localparam int MANT_W = 4;
	localparam int SHIFT_LSB = 4;
	localparam int SHIFT_W = 3;
	localparam int DIG_W = 11;
	// Weight of one resistance unit, in milliohm
	localparam real RES_LSB_MOHM = 9.67;

	localparam logic [7:0] VEN_SL_DEF = 8'h20;
	localparam logic [7:0] VEX_SB_DEF = 8'h30;
	localparam logic [7:0] VEX_SL_DEF = 8'h60;
	localparam int TMR_W = 24;
	localparam int T_ENTER_US = 1000;
	localparam int T_EXIT_US = 100;
	localparam int ENTER_CYC_DEF = T_ENTER_US * CLK_MHZ;
	localparam int EXIT_CYC_DEF = T_EXIT_US * CLK_MHZ;
	localparam int NV_STEP_NS = 1000;
	localparam int NV_STEP_CYC = (NV_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PU_WAIT_MS = 10;
	localparam int PU_WAIT_CYC_DEF = PU_WAIT_MS * 1000 * CLK_MHZ;

	localparam logic [15:0] MCTL_DIS_VAL = 16'h8000;
	localparam logic [15:0] HOST_A_VAL = 16'h8000;
	localparam logic [15:0] CTL_MASS_RD = 16'h0002;
	localparam logic [15:0] CTL_MASS_WR = 16'h0006;

	localparam logic [3:0] H_CTRL = 4'h0;
	localparam logic [3:0] H_PIN = 4'h1;
	localparam logic [3:0] H_STATUS = 4'h2;
	localparam logic [3:0] H_DATA0 = 4'h3;
	localparam int HC_START_WR = 0;
	localparam int HC_START_RD = 1;
	localparam int HC_START_SLEEP = 2;
	localparam int HP_PIN_BIT = 8;
	localparam int SEQ_PRE = 4;

	typedef enum logic [1:0] {SPD_ANALOG = 2'h0, SPD_PWM = 2'h1, SPD_SERIAL = 2'h3} lpn_mode_t;
	typedef enum logic [1:0] {LP_RUN = 2'h0, LP_STANDBY = 2'h1, LP_SLEEP = 2'h3} lpn_lp_t;
	typedef enum logic [2:0] {
		NV_IDLE = 3'h0, NV_UNLOCK = 3'h1, NV_WRITE = 3'h3, NV_READ = 3'h2, NV_LOAD = 3'h6
	} lpn_nv_t;
	typedef enum logic [1:0] {H_IDLE = 2'h0, H_ISSUE = 2'h1, H_WAITR = 2'h3, H_RESP = 2'h2} lpn_hs_t;
	typedef enum logic [1:0] {HOP_WRITE = 2'h0, HOP_READ = 2'h1, HOP_SLEEP = 2'h3} lpn_hop_t;
	typedef enum logic [1:0] {K_WR = 2'h0, K_POLL = 2'h1, K_SAVE = 2'h3, K_END = 2'h2} lpn_kind_t;
	typedef struct packed {
		lpn_kind_t kind;
		logic [7:0] addr;
		logic [15:0] data;
	} lpn_step_t;
endpackage
`default_nettype wire

// File: src/lpn_dev.sv
// Driver end: power states, overvoltage inhibit, NV store with shadow registers.
// Assumes pin and comparator inputs are synchronous and the strap is stable at reset.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module lpn_dev #(
	parameter int ENTER_CYC = lpn_pkg::ENTER_CYC_DEF,
	parameter int EXIT_CYC = lpn_pkg::EXIT_CYC_DEF,
	parameter logic [7:0] VEN_SL = lpn_pkg::VEN_SL_DEF,
	parameter logic [7:0] VEX_SB = lpn_pkg::VEX_SB_DEF,
	parameter logic [7:0] VEX_SL = lpn_pkg::VEX_SL_DEF
) (
	input wire logic clock,
	input wire logic rst,
	lpn_if.dev lk,
	input wire lpn_pkg::lpn_mode_t speed_mode,
	input wire logic variant_sleep,
	input wire logic ov_above_rise,
	input wire logic ov_below_fall,
	output logic drive_en,
	output logic buck_en,
	output logic serial_en,
	output logic sleep_state,
	output logic standby_state,
	output logic [lpn_pkg::SPD_W-1:0] speed_cmd,
	output logic [lpn_pkg::DIG_W-1:0] phase_res_dig,
	output logic [lpn_pkg::DIG_W-1:0] bemf_dig
);
	import lpn_pkg::*;

	typedef struct packed {
		logic strap_taken;
		logic strap_sleep;
		logic ov_block;
		lpn_lp_t lp;
		logic [TMR_W-1:0] tmr;
		logic [15:0] speed;
		logic [15:0] key;
		logic [15:0] ctl;
		logic [15:0] mctl;
		logic [NV_WORDS-1:0][NV_W-1:0] shadow;
		logic [NV_WORDS-1:0][NV_W-1:0] mem;
		lpn_nv_t nv;
		logic key_armed;
		logic unlocked;
		logic ready;
		logic [2:0] widx;
		logic [7:0] wtmr;
		logic [15:0] rdata;
		logic drive_en;
		logic buck_en;
		logic serial_en;
		logic [SPD_W-1:0] speed_out;
		logic [DIG_W-1:0] res_dig;
		logic [DIG_W-1:0] bemf_dig;
		logic sleep_q;
		logic standby_q;
	} lpn_dev_st_t;

	lpn_dev_st_t s;
	lpn_dev_st_t next_s;
	logic [SPD_W-1:0] field;
	logic serial_on;
	logic en_c;
	logic ex_c;
	logic cond;
	logic [TMR_W-1:0] lim;
	logic [2:0] cidx;
	logic [MANT_W-1:0] mant;
	logic [SHIFT_W-1:0] shf;

	always_comb begin
		next_s = s;
		field = s.speed[SPD_LSB +: SPD_W];
		// Sleep turns the serial port off, so nothing on the link reaches the registers
		serial_on = (s.lp != LP_SLEEP);
		cidx = 3'(lk.addr - A_CFG_FIRST);
		next_s.rdata = REG_RESET;
		if (!s.strap_taken) begin
			next_s.strap_taken = 1'b1;
			next_s.strap_sleep = variant_sleep;
		end
		if (ov_above_rise) begin
			next_s.ov_block = 1'b1;
		end else if (ov_below_fall) begin
			next_s.ov_block = 1'b0;
		end

		if (serial_on && lk.rd) begin
			if (lk.addr == A_SPEED) begin
				next_s.rdata = s.speed;
			end else if (lk.addr == A_KEY) begin
				next_s.rdata = s.key;
			end else if (lk.addr == A_STATUS) begin
				next_s.rdata = REG_RESET;
				next_s.rdata[READY_BIT] = s.ready;
			end else if (lk.addr == A_NVCTL) begin
				next_s.rdata = s.ctl;
			end else if (lk.addr == A_MCTL) begin
				next_s.rdata = s.mctl;
			end else if (lk.addr >= A_CFG_FIRST && lk.addr <= A_CFG_LAST) begin
				next_s.rdata = s.shadow[cidx];
			end
		end

		if (serial_on && lk.wr) begin
			if (lk.addr == A_SPEED) begin
				next_s.speed = lk.wdata;
			end else if (lk.addr == A_KEY) begin
				next_s.key = lk.wdata;
				if (lk.wdata == KEY_CLEAR) begin
					next_s.key_armed = 1'b1;
				end else if (lk.wdata == KEY_OPEN && s.key_armed && s.nv == NV_IDLE) begin
					next_s.key_armed = 1'b0;
					next_s.nv = NV_UNLOCK;
					next_s.ready = 1'b0;
					next_s.wtmr = 8'h00;
				end else begin
					// A wrong key closes access again
					next_s.key_armed = 1'b0;
					next_s.unlocked = 1'b0;
					next_s.ready = 1'b0;
				end
			end else if (lk.addr == A_NVCTL) begin
				next_s.ctl = lk.wdata;
				if (s.unlocked && s.nv == NV_IDLE && !lk.wdata[SHADOW_BIT] &&
					!lk.wdata[REFRESH_BIT] &&
					lk.wdata[ACC_MODE_LSB +: 2] == ACC_MODE_MASS) begin
					next_s.nv = lk.wdata[WREN_BIT] ? NV_WRITE : NV_READ;
					next_s.ready = 1'b0;
					next_s.widx = 3'h0;
					next_s.wtmr = 8'h00;
				end
			end else if (lk.addr == A_MCTL) begin
				next_s.mctl = lk.wdata;
			end else if (lk.addr >= A_CFG_FIRST && lk.addr <= A_CFG_LAST) begin
				// Shadows are frozen while the engine walks them
				if (s.nv == NV_IDLE) begin
					next_s.shadow[cidx] = lk.wdata;
				end
			end
		end

		case (s.nv)
			NV_IDLE: begin
				next_s.wtmr = 8'h00;
			end
			NV_UNLOCK: begin
				next_s.wtmr = s.wtmr + 8'h01;
				if (s.wtmr == 8'(NV_STEP_CYC - 1)) begin
					next_s.unlocked = 1'b1;
					next_s.ready = 1'b1;
					next_s.nv = NV_IDLE;
				end
			end
			default: begin
				next_s.wtmr = s.wtmr + 8'h01;
				if (s.wtmr == 8'(NV_STEP_CYC - 1)) begin
					next_s.wtmr = 8'h00;
					if (s.nv == NV_WRITE) begin
						next_s.mem[s.widx] = s.shadow[s.widx];
					end else begin
						next_s.shadow[s.widx] = s.mem[s.widx];
					end
					if (s.widx == 3'(NV_WORDS - 1)) begin
						next_s.nv = NV_IDLE;
						// Power-on load leaves the flag down until a key opens access
						next_s.ready = (s.nv != NV_LOAD);
					end else begin
						next_s.widx = s.widx + 3'h1;
					end
				end
			end
		endcase

		case (speed_mode)
			SPD_ANALOG: en_c = (lk.speed_ana < VEN_SL);
			SPD_PWM: en_c = !lk.speed_pin;
			// Sleep part in serial mode needs host_bit_a set and the driver re-enabled
			default: en_c = (field == '0) && (!s.strap_sleep ||
				(s.speed[HOST_A_BIT] && !s.mctl[MOTOR_DISABLE_BIT_BIT]));
		endcase
		if (s.lp == LP_SLEEP) begin
			case (speed_mode)
				SPD_ANALOG: ex_c = (lk.speed_ana > VEX_SL);
				SPD_PWM: ex_c = lk.speed_pin;
				default: ex_c = lk.speed_pin || (lk.speed_ana > VEX_SL);
			endcase
		end else begin
			case (speed_mode)
				SPD_ANALOG: ex_c = (lk.speed_ana > VEX_SB);
				SPD_PWM: ex_c = lk.speed_pin;
				default: ex_c = (field != '0);
			endcase
		end
		cond = (s.lp == LP_RUN) ? en_c : ex_c;
		lim = (s.lp == LP_RUN) ? TMR_W'(ENTER_CYC - 1) : TMR_W'(EXIT_CYC - 1);

		if (!cond) begin
			next_s.tmr = '0;
		end else if (s.tmr < lim) begin
			next_s.tmr = s.tmr + 1'b1;
		end else begin
			next_s.tmr = '0;
			if (s.lp == LP_RUN && s.strap_sleep) begin
				next_s.lp = LP_SLEEP;
				// Only the NV store and its shadows survive sleep
				next_s.speed = REG_RESET;
				next_s.key = REG_RESET;
				next_s.ctl = REG_RESET;
				next_s.mctl = REG_RESET;
				next_s.key_armed = 1'b0;
				next_s.unlocked = 1'b0;
				next_s.ready = 1'b0;
				next_s.nv = NV_IDLE;
			end else if (s.lp == LP_RUN) begin
				next_s.lp = LP_STANDBY;
			end else begin
				if (s.lp == LP_SLEEP) begin
					next_s.nv = NV_LOAD;
					next_s.widx = 3'h0;
					next_s.wtmr = 8'h00;
				end
				next_s.lp = LP_RUN;
			end
		end

		next_s.drive_en = (next_s.lp == LP_RUN) && !next_s.ov_block &&
			!next_s.mctl[MOTOR_DISABLE_BIT_BIT];
		next_s.buck_en = (next_s.lp != LP_SLEEP);
		next_s.serial_en = (next_s.lp != LP_SLEEP);
		next_s.sleep_q = (next_s.lp == LP_SLEEP);
		next_s.standby_q = (next_s.lp == LP_STANDBY);
		next_s.speed_out = next_s.speed[SPD_LSB +: SPD_W];
		mant = s.shadow[CFG_RES][MANT_LSB +: MANT_W];
		shf = s.shadow[CFG_RES][SHIFT_LSB +: SHIFT_W];
		next_s.res_dig = DIG_W'(mant) << shf;
		mant = s.shadow[CFG_BEMF][MANT_LSB +: MANT_W];
		shf = s.shadow[CFG_BEMF][SHIFT_LSB +: SHIFT_W];
		next_s.bemf_dig = DIG_W'(mant) << shf;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '{lp: LP_RUN, nv: NV_LOAD, mem: {NV_WORDS{NV_ERASED}}, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign lk.rdata = s.rdata;
	assign drive_en = s.drive_en;
	assign buck_en = s.buck_en;
	assign serial_en = s.serial_en;
	assign sleep_state = s.sleep_q;
	assign standby_state = s.standby_q;
	assign speed_cmd = s.speed_out;
	assign phase_res_dig = s.res_dig;
	assign bemf_dig = s.bemf_dig;
endmodule
`default_nettype wire

// File: src/lpn_host.sv
// Host end: runs NV unlock, mass write, mass read and serial sleep entry sequences.
// Software drives it through a small command port; read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module lpn_host #(
	parameter int PU_WAIT_CYC = lpn_pkg::PU_WAIT_CYC_DEF
) (
	input wire logic clock,
	input wire logic rst,
	lpn_if.hst lk,
	input wire logic [3:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [15:0] cmd_rdata
);
	import lpn_pkg::*;

	typedef struct packed {
		lpn_hs_t hs;
		lpn_hop_t op;
		logic [3:0] idx;
		logic [22:0] pu_cnt;
		logic pu_done;
		logic busy;
		logic done;
		logic [NV_WORDS-1:0][NV_W-1:0] data;
		logic pin;
		logic [7:0] ana;
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [15:0] cmd_rdata;
	} lpn_host_st_t;

	lpn_host_st_t s;
	lpn_host_st_t next_s;
	lpn_step_t st;
	logic [3:0] didx;

	function automatic lpn_step_t step_of(lpn_hop_t op, logic [3:0] i,
		logic [NV_WORDS-1:0][NV_W-1:0] d);
		lpn_step_t r;
		r = '{kind: K_END, addr: A_MCTL, data: REG_RESET};
		if (op == HOP_SLEEP) begin
			if (i == 4'd0 || i == 4'd2) begin
				r = '{kind: K_WR, addr: A_MCTL, data: (i == 4'd0) ? MCTL_DIS_VAL : REG_RESET};
			end else if (i == 4'd1 || i == 4'd3) begin
				r = '{kind: K_WR, addr: A_SPEED, data: HOST_A_VAL};
			end
		end else if (i == 4'd0) begin
			r = '{kind: K_WR, addr: A_MCTL, data: MCTL_DIS_VAL};
		end else if (i == 4'd1 || i == 4'd2) begin
			r = '{kind: K_WR, addr: A_KEY, data: (i == 4'd1) ? KEY_CLEAR : KEY_OPEN};
		end else if (i == 4'd3) begin
			r = '{kind: K_POLL, addr: A_STATUS, data: REG_RESET};
		end else if (op == HOP_WRITE) begin
			if (int'(i) < SEQ_PRE + NV_WORDS) begin
				r = '{kind: K_WR, addr: A_CFG_FIRST + 8'(i - 4'(SEQ_PRE)),
					data: d[3'(i - 4'(SEQ_PRE))]};
			end else if (int'(i) == SEQ_PRE + NV_WORDS) begin
				r = '{kind: K_WR, addr: A_NVCTL, data: CTL_MASS_WR};
			end else if (int'(i) == SEQ_PRE + NV_WORDS + 1) begin
				r = '{kind: K_POLL, addr: A_STATUS, data: REG_RESET};
			end else if (int'(i) == SEQ_PRE + NV_WORDS + 2) begin
				r = '{kind: K_WR, addr: A_MCTL, data: REG_RESET};
			end
		end else begin
			if (int'(i) == SEQ_PRE) begin
				r = '{kind: K_WR, addr: A_NVCTL, data: CTL_MASS_RD};
			end else if (int'(i) == SEQ_PRE + 1) begin
				r = '{kind: K_POLL, addr: A_STATUS, data: REG_RESET};
			end else if (int'(i) < SEQ_PRE + 2 + NV_WORDS) begin
				r = '{kind: K_SAVE, addr: A_CFG_FIRST + 8'(i - 4'(SEQ_PRE + 2)),
					data: REG_RESET};
			end else if (int'(i) == SEQ_PRE + 2 + NV_WORDS) begin
				r = '{kind: K_WR, addr: A_MCTL, data: REG_RESET};
			end
		end
		return r;
	endfunction

	always_comb begin
		next_s = s;
		next_s.wr = 1'b0;
		next_s.rd = 1'b0;
		next_s.cmd_rdata = REG_RESET;
		st = step_of(s.op, s.idx, s.data);
		didx = s.idx - 4'(SEQ_PRE + 2);
		if (!s.pu_done) begin
			next_s.pu_cnt = s.pu_cnt + 23'h1;
			next_s.pu_done = (s.pu_cnt == 23'(PU_WAIT_CYC - 1));
		end

		if (cmd_rd) begin
			if (cmd_addr == H_STATUS) begin
				next_s.cmd_rdata = {13'h0000, s.pu_done, s.done, s.busy};
			end else if (cmd_addr == H_PIN) begin
				next_s.cmd_rdata = {7'h00, s.pin, s.ana};
			end else if (cmd_addr >= H_DATA0 && cmd_addr < H_DATA0 + 4'(NV_WORDS)) begin
				next_s.cmd_rdata = s.data[3'(cmd_addr - H_DATA0)];
			end
		end
		if (cmd_wr) begin
			if (cmd_addr == H_CTRL && s.hs == H_IDLE && cmd_wdata[2:0] != 3'h0) begin
				next_s.op = cmd_wdata[HC_START_WR] ? HOP_WRITE :
					(cmd_wdata[HC_START_RD] ? HOP_READ : HOP_SLEEP);
				next_s.hs = H_ISSUE;
				next_s.idx = 4'h0;
				next_s.busy = 1'b1;
				next_s.done = 1'b0;
			end else if (cmd_addr == H_PIN) begin
				next_s.pin = cmd_wdata[HP_PIN_BIT];
				next_s.ana = cmd_wdata[7:0];
			end else if (cmd_addr >= H_DATA0 && cmd_addr < H_DATA0 + 4'(NV_WORDS) &&
				s.hs == H_IDLE) begin
				next_s.data[3'(cmd_addr - H_DATA0)] = cmd_wdata;
			end
		end

		case (s.hs)
			H_ISSUE: begin
				// NV sequences hold off until the supply has settled; sleep entry does not
				if (s.pu_done || s.op == HOP_SLEEP) begin
					next_s.addr = st.addr;
					next_s.wdata = st.data;
					if (st.kind == K_WR) begin
						next_s.wr = 1'b1;
						next_s.idx = s.idx + 4'h1;
					end else if (st.kind == K_END) begin
						next_s.hs = H_IDLE;
						next_s.busy = 1'b0;
						next_s.done = 1'b1;
					end else begin
						next_s.rd = 1'b1;
						next_s.hs = H_WAITR;
					end
				end
			end
			H_WAITR: begin
				next_s.hs = H_RESP;
			end
			H_RESP: begin
				next_s.hs = H_ISSUE;
				if (st.kind == K_SAVE) begin
					next_s.data[3'(didx)] = lk.rdata;
					next_s.idx = s.idx + 4'h1;
				end else if (lk.rdata[READY_BIT]) begin
					next_s.idx = s.idx + 4'h1;
				end
			end
			default: begin
				// Idle: a start is taken by the command port above, so keep its next state
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '{hs: H_IDLE, op: HOP_WRITE, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign lk.wr = s.wr;
	assign lk.rd = s.rd;
	assign lk.addr = s.addr;
	assign lk.wdata = s.wdata;
	assign lk.speed_pin = s.pin;
	assign lk.speed_ana = s.ana;
	assign cmd_rdata = s.cmd_rdata;
endmodule
`default_nettype wire

// File: verif/lpn_checker.sv
// Assertions on the link between the host and driver ends of the low-power block.
// Assumes one clock for both ends; watches link signals and the driver state outputs.
`timescale 1ns/1ps
`default_nettype none
module lpn_checker
	import lpn_pkg::*;
#(
	parameter int ENTER_CYC = ENTER_CYC_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic speed_pin,
	input wire lpn_pkg::lpn_mode_t speed_mode,
	input wire logic ov_above_rise,
	input wire logic drive_en,
	input wire logic buck_en,
	input wire logic serial_en,
	input wire logic sleep_state,
	input wire logic standby_state
);
	// Consecutive low cycles of the speed pin; 16 bits outlast any low spell of the run
	logic [15:0] low_cnt;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_cnt <= 16'h0000;
		end else begin
			low_cnt <= speed_pin ? 16'h0000 : low_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_key_open;
		wr && addr == A_KEY && wdata == KEY_OPEN && !sleep_state;
	endsequence
	sequence s_nv_start;
		wr && addr == A_NVCTL && (wdata == CTL_MASS_WR || wdata == CTL_MASS_RD) && !sleep_state;
	endsequence
	sequence s_status_rd;
		rd && addr == A_STATUS && !sleep_state;
	endsequence

	property p_ov_stop;
		ov_above_rise |=> !drive_en;
	endproperty
	property p_lp_stop;
		(sleep_state || standby_state) && $past(sleep_state || standby_state) |-> !drive_en;
	endproperty
	property p_sleep_off;
		sleep_state && $past(sleep_state) |-> !buck_en && !serial_en;
	endproperty
	property p_standby_keep;
		standby_state && $past(standby_state) |-> buck_en && serial_en;
	endproperty
	property p_key_ready;
		s_key_open ##1 s_status_rd |=> !rdata[READY_BIT];
	endproperty
	property p_nv_busy;
		s_nv_start ##[1:3] s_status_rd |=> !rdata[READY_BIT];
	endproperty
	property p_motor_disable_bit;
		wr && addr == A_MCTL && wdata[MOTOR_DISABLE_BIT_BIT] && !sleep_state |-> ##2 !drive_en;
	endproperty
	property p_pwm_entry;
		$rose(standby_state) && speed_mode == SPD_PWM |-> low_cnt >= ENTER_CYC - 1;
	endproperty
	property p_sleep_deaf;
		sleep_state && rd |=> rdata == 16'h0000;
	endproperty

	a_ov_stop: assert property (p_ov_stop) else $error("drive on above threshold");
	a_lp_stop: assert property (p_lp_stop) else $error("drive on in low power");
	a_sleep_off: assert property (p_sleep_off) else $error("regulator on in sleep");
	a_standby_keep: assert property (p_standby_keep) else $error("standby lost port");
	a_key_ready: assert property (p_key_ready) else $error("ready during unlock");
	a_nv_busy: assert property (p_nv_busy) else $error("ready during mass op");
	a_motor_disable_bit: assert property (p_motor_disable_bit) else $error("drive on when disabled");
	a_pwm_entry: assert property (p_pwm_entry) else $error("standby entered early");
	a_sleep_deaf: assert property (p_sleep_deaf) else $error("read answered in sleep");
endmodule
`default_nettype wire

// File: verif/test_lowpower_and_nvm_access_ctrl.sv
// Testbench: host end and driver end joined by the link, driven from the host command port.
// Assumes shortened power-state and power-up counts; NV store is cleared by each reset.
`timescale 1ns/1ps
`default_nettype none
module test_lowpower_and_nvm_access_ctrl;
	import lpn_pkg::*;
	localparam int ENTER = 20;
	localparam int EXIT = 10;
	// Power-up wait must outlast the 280-cycle shadow load, or the key lands mid-load
	localparam int PU = 300;
	logic clock = 1'b0;
	logic rst = 1'b1;
	lpn_mode_t speed_mode = SPD_PWM;
	logic variant_sleep = 1'b0;
	logic ov_above_rise = 1'b0;
	logic ov_below_fall = 1'b1;
	logic [3:0] cmd_addr = 4'h0;
	logic [15:0] cmd_wdata = 16'h0000;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [15:0] cmd_rdata;
	logic drive_en;
	logic buck_en;
	logic serial_en;
	logic sleep_state;
	logic standby_state;
	logic [SPD_W-1:0] speed_cmd;
	logic [DIG_W-1:0] phase_res_dig;
	logic [DIG_W-1:0] bemf_dig;
	logic [15:0] rd_val;
	logic [15:0] nv_img [7] = '{16'h002B, 16'h007F, 16'h1234, 16'hA5A5, 16'h5A5A, 16'hFFFF, 16'h8001};
	int err_count = 0;
	int checked = 0;

	lpn_if lk ();
	lpn_dev #(.ENTER_CYC(ENTER), .EXIT_CYC(EXIT)) u_lpn_dev (.clock(clock), .rst(rst), .lk(lk),
		.speed_mode(speed_mode), .variant_sleep(variant_sleep), .ov_above_rise(ov_above_rise),
		.ov_below_fall(ov_below_fall), .drive_en(drive_en), .buck_en(buck_en),
		.serial_en(serial_en), .sleep_state(sleep_state), .standby_state(standby_state),
		.speed_cmd(speed_cmd), .phase_res_dig(phase_res_dig), .bemf_dig(bemf_dig));
	lpn_host #(.PU_WAIT_CYC(PU)) u_lpn_host (.clock(clock), .rst(rst), .lk(lk),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_rdata(cmd_rdata));
	lpn_checker #(.ENTER_CYC(ENTER)) u_lpn_checker (.clock(clock), .rst(rst), .wr(lk.wr),
		.rd(lk.rd), .addr(lk.addr), .wdata(lk.wdata), .rdata(lk.rdata), .speed_pin(lk.speed_pin),
		.speed_mode(speed_mode), .ov_above_rise(ov_above_rise), .drive_en(drive_en),
		.buck_en(buck_en), .serial_en(serial_en), .sleep_state(sleep_state),
		.standby_state(standby_state));

	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic hwr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clock);
		cmd_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic hrd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clock);
		cmd_rd <= 1'b0;
		#1;
		d = cmd_rdata;
	endtask

	task automatic do_reset(input logic v, input lpn_mode_t m);
		@(posedge clock);
		rst <= 1'b1;
		variant_sleep <= v;
		speed_mode <= m;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
	endtask

	task automatic run_cmd(input logic [15:0] c);
		int n;
		n = 0;
		hwr(H_CTRL, c);
		do begin
			hrd(H_STATUS, rd_val);
			n++;
		end while (rd_val[1:0] !== 2'b10 && n < 3000);
		cmp(rd_val & 16'h0003, 16'h0002, "sequence done");
	endtask

	// Expected bits: drive, regulator, serial port, sleep, standby
	task automatic pin_chk(input logic [15:0] p, input int w, input logic [4:0] e);
		hwr(H_PIN, p);
		wt(w);
		cmp({11'h000, drive_en, buck_en, serial_en, sleep_state, standby_state}, {11'h000, e},
			"power state");
	endtask

	task automatic t_power_up();
		hrd(H_STATUS, rd_val);
		cmp(rd_val & 16'h0004, 16'h0000, "power-up wait");
		wt(PU);
		hrd(H_STATUS, rd_val);
		cmp(rd_val & 16'h0004, 16'h0004, "power-up over");
		cmp({12'h000, drive_en, buck_en, serial_en, standby_state}, 16'h000E, "run");
	endtask

	task automatic t_ov();
		@(posedge clock);
		ov_above_rise <= 1'b1;
		ov_below_fall <= 1'b0;
		wt(3);
		cmp({15'h0000, drive_en}, 16'h0000, "ov stop");
		@(posedge clock);
		ov_above_rise <= 1'b0;
		wt(3);
		cmp({15'h0000, drive_en}, 16'h0000, "ov hysteresis");
		@(posedge clock);
		ov_below_fall <= 1'b1;
		wt(3);
		cmp({15'h0000, drive_en}, 16'h0001, "ov resume");
	endtask

	task automatic t_pwm_standby();
		pin_chk(16'h0000, ENTER / 2, 5'b11100);
		pin_chk(16'h0100, ENTER, 5'b11100);
		pin_chk(16'h0000, ENTER + 5, 5'b01101);
		pin_chk(16'h0100, EXIT + 5, 5'b11100);
	endtask

	task automatic t_analog_standby();
		@(posedge clock);
		speed_mode <= SPD_ANALOG;
		pin_chk(16'h0010, ENTER + 5, 5'b01101);
		pin_chk(16'h0028, EXIT + 5, 5'b01101);
		pin_chk(16'h0040, EXIT + 5, 5'b11100);
	endtask

	task automatic t_mass_write();
		for (int i = 0; i < NV_WORDS; i++) begin
			hwr(H_DATA0 + 4'(i), nv_img[i]);
		end
		run_cmd(16'h0001);
		cmp({5'h00, phase_res_dig}, 16'h002C, "resistance");
		cmp({5'h00, bemf_dig}, 16'h0780, "bemf");
		cmp({15'h0000, drive_en}, 16'h0001, "drive back");
	endtask

	task automatic t_mass_read();
		for (int i = 0; i < NV_WORDS; i++) begin
			hwr(H_DATA0 + 4'(i), 16'h0000);
		end
		run_cmd(16'h0002);
		for (int i = 0; i < NV_WORDS; i++) begin
			hrd(H_DATA0 + 4'(i), rd_val);
			cmp(rd_val, nv_img[i], "nv word");
		end
	endtask

	task automatic t_serial_sleep();
		run_cmd(16'h0004);
		wt(ENTER + 5);
		cmp({11'h000, drive_en, buck_en, serial_en, sleep_state, standby_state}, 16'h0002,
			"sleep");
		cmp({7'h00, speed_cmd}, 16'h0000, "speed cleared");
		// Link writes in sleep must not land: the wake check expects drive back on
		run_cmd(16'h0004);
		// Wake waits out the shadow reload as well
		pin_chk(16'h0100, EXIT + 300, 5'b11100);
		cmp({5'h00, phase_res_dig}, 16'h002C, "reload");
	endtask

	task automatic t_analog_sleep();
		@(posedge clock);
		speed_mode <= SPD_ANALOG;
		pin_chk(16'h0010, ENTER + 5, 5'b00010);
		pin_chk(16'h0040, EXIT + 5, 5'b00010);
		pin_chk(16'h0070, EXIT + 5, 5'b11100);
	endtask

	initial begin
		repeat (60000) @(posedge clock);
		err_count++;
		test_done();
	end

	initial begin
		do_reset(1'b0, SPD_PWM);
		hwr(H_PIN, 16'h0100);
		t_power_up();
		t_ov();
		t_pwm_standby();
		t_analog_standby();
		do_reset(1'b1, SPD_SERIAL);
		t_mass_write();
		t_mass_read();
		t_serial_sleep();
		t_analog_sleep();
		test_done();
	end
endmodule
`default_nettype wire
